// ==== logic/word_asm_pkg.sv ====
package word_asm_pkg;

   // ------------------------------------------------------------
   // Clock and timing
   // ------------------------------------------------------------
   localparam int CLK_MHZ = 100;
   localparam int SCLK_PULSE_NS = 1000;
   localparam int SCLK_PULSE_CYC = (SCLK_PULSE_NS * CLK_MHZ + 999) / 1000;
   localparam int EMD_PULSE_NS = 2000;
   localparam int EMD_PULSE_CYC = (EMD_PULSE_NS * CLK_MHZ + 999) / 1000;
   localparam int TIMER_W = 8;

   // ------------------------------------------------------------
   // Register map (byte addresses)
   // ------------------------------------------------------------
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h4;
   localparam logic [3:0] ADDR_FRAMES = 4'h8;
   localparam logic [3:0] ADDR_WORD_HI = 4'hc;

   localparam int CTRL_GO_BIT = 0;
   localparam int CTRL_FUNC_LSB = 1;
   localparam int CTRL_FUNC_W = 5;
   localparam int CTRL_FMT_LSB = 8;
   localparam int FMT_W = 4;

   localparam logic [4:0] FUNC_RESET = 5'h00;
   localparam logic [3:0] FMT_RESET = 4'h0;
   localparam logic [4:0] FUNC_XFER_MASK = 5'h18;
   localparam logic [4:0] FUNC_XFER_MATCH = 5'h18;

   localparam int ST_OCC_BIT = 0;
   localparam int ST_EN_BIT = 1;
   localparam int ST_GO_BIT = 2;
   localparam int ST_FMTE_BIT = 3;
   localparam int ST_OVF_BIT = 4;
   localparam int ST_LATE_BIT = 5;
   localparam int ST_STATE_LSB = 8;
   localparam int ST_POS_LSB = 12;

   // ------------------------------------------------------------
   // Formats
   // ------------------------------------------------------------
   localparam logic [3:0] FMT_CORE_DUMP = 4'h0;
   localparam logic [3:0] FMT_SEVEN_TRACK = 4'h1;
   localparam logic [3:0] FMT_ASCII = 4'h2;
   localparam logic [3:0] FMT_COMPAT = 4'h3;

   localparam logic [2:0] FRAMES_CORE_DUMP = 3'h5;
   localparam logic [2:0] FRAMES_SEVEN_TRACK = 3'h6;
   localparam logic [2:0] FRAMES_ASCII = 3'h5;
   localparam logic [2:0] FRAMES_COMPAT = 3'h4;

   localparam int SECTIONS = 6;
   localparam int HALF_W = 18;
   localparam logic PARITY_ODD = 1'b1;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      SEQ_OFF     = 3'b000,
      SEQ_COLLECT = 3'b001,
      SEQ_ALIGN   = 3'b010,
      SEQ_DONE    = 3'b011,
      SEQ_SCLK1   = 3'b100,
      SEQ_WAIT1   = 3'b101,
      SEQ_SCLK2   = 3'b110,
      SEQ_WAIT2   = 3'b111
   } seq_state_t;

   typedef struct packed {
      logic [HALF_W-1:0] data;
      logic parity;
   } half_word_t;

   typedef struct packed {
      logic first;
      logic load_sel;
      logic third;
   } state_outs_t;

endpackage

// ==== logic/tape_frame_word_assembler.sv ====
`timescale 1ns/1ps

// Summary of operation
// RULE_01: Transfer function decoded asserts occupied and enable
// RULE_02: Sequencer runs only with enable and go
// RULE_03: Run gives drive-set, delay, then init one-shot
// RULE_04: Init state: first high, others low
// RULE_05: Format code picks mode and frames
// RULE_06: Undefined format code raises format error
// RULE_07: Frames gathered into 36-bit word
// RULE_08: Each strobe advances position and frame count
// RULE_09: Position counter addresses section load table
// RULE_10: Later strobes skip already-loaded low sections
// RULE_11: Match when position equals format frames
// RULE_12: Match steps sequencer, word shifted left
// RULE_13: Word done clock starts with the first of two slave clocks
// RULE_14: Each write clock drives next half word
// RULE_15: Parity driven with each half word
// RULE_16: After both halves return to initial state
// RULE_17: Every slave clock preloads position counter
// RULE_18: Frame count overflow drops assembler enable
// RULE_19: Word crosses as two 18-bit halves
// RULE_20: One-shot pulses on delay falling edge
module tape_frame_word_assembler #(
   parameter int FRAME_COUNT_W = 16
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic read_char_strobe,
   input wire logic [7:0] read_char_lines,
   input wire logic write_clock,
   output word_asm_pkg::half_word_t host_half,
   output logic slave_clock,
   output logic transfer_occupied,
   output logic assembler_enable,
   output logic drive_set_pulse,
   output logic end_motion_delay_pulse,
   output logic format_error,
   output word_asm_pkg::state_outs_t state_outs
);
   import word_asm_pkg::*;

   if (FRAME_COUNT_W < 4 || FRAME_COUNT_W > 32) begin : g_bad_fc
      $error("FRAME_COUNT_W must lie in 4..32");
   end
   if (SCLK_PULSE_CYC >= (1 << TIMER_W) ||
       EMD_PULSE_CYC >= (1 << TIMER_W)) begin : g_bad_timer
      $error("Pulse counts do not fit the timer");
   end

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   logic [9:0] pin_meta_q;
   logic [9:0] pin_sync_q;
   logic strobe_prev_q;
   logic wclk_prev_q;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pin_meta_q <= 10'h000;
         pin_sync_q <= 10'h000;
      end else begin
         pin_meta_q <= {write_clock, read_char_strobe, read_char_lines};
         pin_sync_q <= pin_meta_q;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         strobe_prev_q <= 1'b0;
         wclk_prev_q <= 1'b0;
      end else begin
         strobe_prev_q <= pin_sync_q[8];
         wclk_prev_q <= pin_sync_q[9];
      end
   end

   logic strobe_rise;
   logic wclk_rise;
   logic [7:0] char_in;
   assign strobe_rise = pin_sync_q[8] & ~strobe_prev_q;
   assign wclk_rise = pin_sync_q[9] & ~wclk_prev_q;
   assign char_in = pin_sync_q[7:0];

   // ------------------------------------------------------------
   // Bus slave
   // ------------------------------------------------------------
   logic waitrequest_q;
   logic [31:0] readdata_q;
   logic [CTRL_FUNC_W-1:0] func_q;
   logic [FMT_W-1:0] fmt_q;
   logic [FRAME_COUNT_W-1:0] frames_q;
   logic bus_req;
   logic wr_take;
   logic ctrl_wr;
   logic xfer_code;
   logic run_req;

   assign bus_req = avs_read | avs_write;
   assign wr_take = avs_write & ~waitrequest_q;
   assign ctrl_wr = wr_take && avs_address == ADDR_CTRL;
   assign xfer_code = (avs_writedata[CTRL_FUNC_LSB +: CTRL_FUNC_W]
                       & FUNC_XFER_MASK) == FUNC_XFER_MATCH;
   assign run_req = ctrl_wr & xfer_code & avs_writedata[CTRL_GO_BIT];

   // One wait cycle, then the answer
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         waitrequest_q <= 1'b1;
      end else begin
         waitrequest_q <= ~(bus_req & waitrequest_q);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         func_q <= FUNC_RESET;
         fmt_q <= FMT_RESET;
      end else if (ctrl_wr) begin
         func_q <= avs_writedata[CTRL_FUNC_LSB +: CTRL_FUNC_W];
         fmt_q <= avs_writedata[CTRL_FMT_LSB +: FMT_W];
      end
   end

   // ------------------------------------------------------------
   // Control levels
   // ------------------------------------------------------------
   logic occupied_q;
   logic enable_q;
   logic go_buf_q;
   logic fmt_err_q;
   logic overflow_q;
   logic late_q;
   logic end_run;
   seq_state_t state_q;
   logic [2:0] pos_q;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         occupied_q <= 1'b0;
      end else begin
         occupied_q <= (func_q & FUNC_XFER_MASK) == FUNC_XFER_MATCH; // see RULE_01
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         fmt_err_q <= 1'b0;
      end else begin
         fmt_err_q <= fmt_q > FMT_COMPAT; // see RULE_06
      end
   end

   // Last word already sent once overflow is seen between words
   assign end_run = overflow_q && state_q == SEQ_COLLECT && pos_q == 3'h0;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         enable_q <= 1'b0;
         go_buf_q <= 1'b0;
      end else if (ctrl_wr) begin
         enable_q <= xfer_code; // see RULE_01
         go_buf_q <= run_req;
      end else if (end_run) begin
         enable_q <= 1'b0; // see RULE_18
         go_buf_q <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Run start: drive set, motion delay, one-shot
   // ------------------------------------------------------------
   logic dset_q;
   logic emd_q;
   logic emd_prev_q;
   logic init_pulse_q;
   logic [TIMER_W-1:0] emd_cnt_q;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dset_q <= 1'b0;
      end else begin
         dset_q <= run_req; // see RULE_03
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         emd_q <= 1'b0;
         emd_cnt_q <= '0;
      end else if (dset_q) begin
         emd_q <= 1'b1; // see RULE_03
         emd_cnt_q <= TIMER_W'(EMD_PULSE_CYC - 1);
      end else if (emd_cnt_q != '0) begin
         emd_cnt_q <= emd_cnt_q - 1'b1;
      end else begin
         emd_q <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         emd_prev_q <= 1'b0;
         init_pulse_q <= 1'b0;
      end else begin
         emd_prev_q <= emd_q;
         init_pulse_q <= emd_prev_q & ~emd_q; // see RULE_20
      end
   end

   // ------------------------------------------------------------
   // Frame position and frame count
   // ------------------------------------------------------------
   logic [2:0] frames_need;
   logic match;
   logic take;
   logic seq_run;
   logic sclk_q;
   logic [TIMER_W-1:0] sclk_cnt_q;

   always_comb begin
      case (fmt_q)
         FMT_CORE_DUMP: frames_need = FRAMES_CORE_DUMP; // see RULE_05
         FMT_SEVEN_TRACK: frames_need = FRAMES_SEVEN_TRACK;
         FMT_ASCII: frames_need = FRAMES_ASCII;
         FMT_COMPAT: frames_need = FRAMES_COMPAT;
         default: frames_need = FRAMES_COMPAT;
      endcase
   end

   assign seq_run = enable_q & go_buf_q; // see RULE_02
   assign match = pos_q == frames_need; // see RULE_11
   assign take = strobe_rise && seq_run && state_q == SEQ_COLLECT &&
                 !match && !fmt_err_q;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pos_q <= 3'h0;
      end else if (init_pulse_q || (sclk_q && sclk_cnt_q == '0)) begin
         pos_q <= 3'h0; // see RULE_17
      end else if (take) begin
         pos_q <= pos_q + 3'h1; // see RULE_08
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         frames_q <= '0;
      end else if (wr_take && avs_address == ADDR_FRAMES) begin
         frames_q <= avs_writedata[FRAME_COUNT_W-1:0];
      end else if (take) begin
         frames_q <= frames_q + 1'b1; // see RULE_08
      end
   end

   // Set wins over the clear made by a new run
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         overflow_q <= 1'b0;
      end else if (take && &frames_q) begin
         overflow_q <= 1'b1; // see RULE_18
      end else if (run_req) begin
         overflow_q <= 1'b0;
      end
   end

   // Strobe lost while the word was being handed over
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         late_q <= 1'b0;
      end else if (strobe_rise && seq_run && !take) begin
         late_q <= 1'b1;
      end else if (run_req) begin
         late_q <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Data shift register sections
   // ------------------------------------------------------------
   logic [SECTIONS-1:0] load_mask;
   logic [7:0] sec_q [SECTIONS];

   assign load_mask = 6'h3f << pos_q; // see RULE_09 RULE_10

   for (genvar g = 0; g < SECTIONS; g++) begin : g_sec
      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            sec_q[g] <= 8'h00;
         end else if (take && load_mask[g]) begin
            sec_q[g] <= char_in; // see RULE_07
         end
      end
   end

   // Left alignment of the frames into the word
   logic [35:0] aligned;
   always_comb begin
      case (fmt_q)
         FMT_SEVEN_TRACK: aligned = {sec_q[0][5:0], sec_q[1][5:0],
            sec_q[2][5:0], sec_q[3][5:0], sec_q[4][5:0], sec_q[5][5:0]};
         FMT_ASCII: aligned = {sec_q[0][6:0], sec_q[1][6:0],
            sec_q[2][6:0], sec_q[3][6:0], sec_q[4]};
         FMT_COMPAT: aligned = {sec_q[0], sec_q[1], sec_q[2], sec_q[3],
            4'h0};
         default: aligned = {sec_q[0], sec_q[1], sec_q[2], sec_q[3],
            sec_q[4][3:0]};
      endcase
   end

   logic [35:0] word_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         word_q <= 36'h000000000;
      end else if (state_q == SEQ_ALIGN) begin
         word_q <= aligned; // see RULE_12
      end
   end

   // ------------------------------------------------------------
   // Sequencing state register
   // ------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q <= SEQ_OFF;
      end else if (!seq_run) begin
         state_q <= SEQ_OFF; // see RULE_02
      end else if (init_pulse_q) begin
         state_q <= SEQ_COLLECT; // see RULE_03 RULE_04
      end else begin
         case (state_q)
            SEQ_COLLECT: if (match) state_q <= SEQ_ALIGN; // see RULE_12
            SEQ_ALIGN: state_q <= SEQ_DONE;
            SEQ_DONE: state_q <= SEQ_SCLK1; // see RULE_13
            SEQ_SCLK1: if (sclk_cnt_q == '0) state_q <= SEQ_WAIT1;
            SEQ_WAIT1: if (wclk_rise) state_q <= SEQ_SCLK2; // see RULE_14
            SEQ_SCLK2: if (sclk_cnt_q == '0) state_q <= SEQ_WAIT2;
            SEQ_WAIT2: if (wclk_rise) state_q <= SEQ_COLLECT; // see RULE_16
            default: state_q <= SEQ_OFF;
         endcase
      end
   end

   state_outs_t souts_q;
   logic word_done_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         souts_q <= '0;
         word_done_q <= 1'b0;
      end else begin
         souts_q.first <= state_q == SEQ_COLLECT; // see RULE_04
         souts_q.load_sel <= state_q == SEQ_ALIGN || state_q == SEQ_DONE;
         souts_q.third <= state_q[2];
         word_done_q <= state_q == SEQ_DONE; // see RULE_13
      end
   end

   // ------------------------------------------------------------
   // Slave clock pulses and half-word output
   // ------------------------------------------------------------
   logic sclk_start;
   assign sclk_start = seq_run && !init_pulse_q &&
      (state_q == SEQ_DONE || (state_q == SEQ_WAIT1 && wclk_rise));

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sclk_q <= 1'b0;
         sclk_cnt_q <= '0;
      end else if (sclk_start) begin
         sclk_q <= 1'b1; // see RULE_13
         sclk_cnt_q <= TIMER_W'(SCLK_PULSE_CYC - 1);
      end else if (sclk_cnt_q != '0) begin
         sclk_cnt_q <= sclk_cnt_q - 1'b1;
      end else begin
         sclk_q <= 1'b0;
      end
   end

   half_word_t half_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         half_q <= '0;
      end else if (wclk_rise && seq_run && state_q == SEQ_WAIT1) begin
         half_q.data <= word_q[35:18]; // see RULE_14 RULE_19
         half_q.parity <= ^word_q[35:18] ^ PARITY_ODD; // see RULE_15
      end else if (wclk_rise && seq_run && state_q == SEQ_WAIT2) begin
         half_q.data <= word_q[17:0]; // see RULE_14 RULE_19
         half_q.parity <= ^word_q[17:0] ^ PARITY_ODD; // see RULE_15
      end
   end

   // ------------------------------------------------------------
   // Read data
   // ------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         readdata_q <= 32'h00000000;
      end else if (avs_read && waitrequest_q) begin
         readdata_q <= 32'h00000000;
         case (avs_address)
            ADDR_CTRL: begin
               readdata_q[CTRL_FUNC_LSB +: CTRL_FUNC_W] <= func_q;
               readdata_q[CTRL_FMT_LSB +: FMT_W] <= fmt_q;
               readdata_q[CTRL_GO_BIT] <= go_buf_q;
            end
            ADDR_STATUS: begin
               readdata_q[ST_OCC_BIT] <= occupied_q;
               readdata_q[ST_EN_BIT] <= enable_q;
               readdata_q[ST_GO_BIT] <= go_buf_q;
               readdata_q[ST_FMTE_BIT] <= fmt_err_q;
               readdata_q[ST_OVF_BIT] <= overflow_q;
               readdata_q[ST_LATE_BIT] <= late_q;
               readdata_q[ST_STATE_LSB +: 3] <= state_q;
               readdata_q[ST_POS_LSB +: 3] <= pos_q;
            end
            ADDR_FRAMES: readdata_q[FRAME_COUNT_W-1:0] <= frames_q;
            ADDR_WORD_HI: readdata_q[HALF_W-1:0] <= word_q[35:18];
            default: readdata_q <= 32'h00000000;
         endcase
      end
   end

   assign avs_readdata = readdata_q;
   assign avs_waitrequest = waitrequest_q;
   assign host_half = half_q;
   assign slave_clock = sclk_q;
   assign transfer_occupied = occupied_q;
   assign assembler_enable = enable_q;
   assign drive_set_pulse = dset_q;
   assign end_motion_delay_pulse = emd_q;
   assign format_error = fmt_err_q;
   assign state_outs = souts_q;

endmodule // tape_frame_word_assembler

// ==== tb/word_asm_sva.sv ====
`timescale 1ns/1ps
module word_asm_sva #(
   parameter int FRAME_COUNT_W = 16
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic read_char_strobe,
   input wire logic [7:0] read_char_lines,
   input wire logic write_clock,
   input wire word_asm_pkg::half_word_t host_half,
   input wire logic slave_clock,
   input wire logic transfer_occupied,
   input wire logic assembler_enable,
   input wire logic drive_set_pulse,
   input wire logic end_motion_delay_pulse,
   input wire logic format_error,
   input wire word_asm_pkg::state_outs_t state_outs
);
   import word_asm_pkg::*;
   // ------------------------------------------------------------
   // Pulse width counters
   // ------------------------------------------------------------
   logic [11:0] emd_cnt_q;
   logic [11:0] sclk_cnt_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) emd_cnt_q <= '0;
      else emd_cnt_q <= end_motion_delay_pulse ? emd_cnt_q + 12'h1 : 12'h0;
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) sclk_cnt_q <= '0;
      else sclk_cnt_q <= slave_clock ? sclk_cnt_q + 12'h1 : 12'h0;
   end
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   a_wait_one_cycle: assert property ((avs_read || avs_write) &&
      avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("bus answer not one cycle");
   a_emd_follows: assert property (
      $rose(drive_set_pulse) |=> $rose(end_motion_delay_pulse))
      else $error("delay pulse not after drive set");
   a_drive_single: assert property (
      drive_set_pulse |=> !drive_set_pulse)
      else $error("drive set pulse too long");
   a_emd_width: assert property (
      $fell(end_motion_delay_pulse) |-> emd_cnt_q == EMD_PULSE_CYC)
      else $error("delay pulse width wrong");
   a_init_after: assert property (
      $fell(end_motion_delay_pulse) |-> ##[1:6] (state_outs == 3'b100))
      else $error("no initial state after delay");
   a_sclk_width: assert property (
      $fell(slave_clock) |-> sclk_cnt_q == SCLK_PULSE_CYC)
      else $error("slave clock width wrong");
   a_half_parity: assert property (
      $changed(host_half) |-> ^host_half)
      else $error("half word parity not odd");
   a_half_on_wclk: assert property (
      $changed(host_half) |-> $past(write_clock))
      else $error("half word changed without write clock");
   a_off_when_idle: assert property (
      !assembler_enable [*3] |-> !state_outs.first)
      else $error("sequencer active while disabled");
   a_sclk_enabled: assert property (
      slave_clock |-> assembler_enable)
      else $error("slave clock while disabled");
endmodule // word_asm_sva

bind tape_frame_word_assembler word_asm_sva #(
   .FRAME_COUNT_W(FRAME_COUNT_W)
) i_sva (.clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
   .avs_readdata, .avs_waitrequest, .read_char_strobe, .read_char_lines,
   .write_clock, .host_half, .slave_clock, .transfer_occupied,
   .assembler_enable, .drive_set_pulse, .end_motion_delay_pulse,
   .format_error, .state_outs);

// ==== tb/host_bus_model.sv ====
`timescale 1ns/1ps
module host_bus_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] lag,
   input wire logic slave_clock,
   input wire word_asm_pkg::half_word_t host_half,
   output logic write_clock,
   output logic [35:0] got_word,
   output logic [1:0] got_par,
   output logic [7:0] n_half
);
   import word_asm_pkg::*;
   // ------------------------------------------------------------
   // One write clock per slave clock, after the pulse ends
   // ------------------------------------------------------------
   initial begin
      write_clock = 1'b0;
      got_word = '0;
      got_par = '0;
      n_half = '0;
      @(negedge rst);
      forever begin
         @(negedge slave_clock);
         repeat (lag) @(posedge clk);
         write_clock <= 1'b1;
         repeat (8) @(posedge clk);
         got_word <= {got_word[17:0], host_half.data};
         got_par <= {got_par[0], host_half.parity};
         n_half <= n_half + 8'h1;
         write_clock <= 1'b0;
      end
   end
endmodule // host_bus_model

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
module testbench;
   import word_asm_pkg::*;
   logic clk, rst, avs_read, avs_write, read_char_strobe, write_clock;
   logic avs_waitrequest, slave_clock, transfer_occupied, assembler_enable;
   logic drive_set_pulse, end_motion_delay_pulse, format_error;
   logic [3:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, rd;
   logic [7:0] read_char_lines, lag, n_half;
   logic [35:0] got_word;
   logic [1:0] got_par;
   half_word_t host_half;
   state_outs_t state_outs;
   int n_mismatch, n_checks, cyc;

   tape_frame_word_assembler i_dut (.clk, .rst, .avs_address, .avs_read,
      .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
      .read_char_strobe, .read_char_lines, .write_clock, .host_half,
      .slave_clock, .transfer_occupied, .assembler_enable, .drive_set_pulse,
      .end_motion_delay_pulse, .format_error, .state_outs);
   host_bus_model i_host (.clk, .rst, .lag, .slave_clock, .host_half,
      .write_clock, .got_word, .got_par, .n_half);

   // ------------------------------------------------------------
   // Bus and pin tasks
   // ------------------------------------------------------------
   task automatic check(input string what, input logic [35:0] seen,
         input logic [35:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= 1'b1;
      @(posedge clk);
      for (int k = 0; k < 50 && avs_waitrequest !== 1'b0; k++) @(posedge clk);
      avs_write <= 1'b0;
      @(posedge clk);
   endtask

   task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
      avs_address <= a;
      avs_read <= 1'b1;
      @(posedge clk);
      for (int k = 0; k < 50 && avs_waitrequest !== 1'b0; k++) @(posedge clk);
      d = avs_readdata;
      avs_read <= 1'b0;
      @(posedge clk);
   endtask

   function automatic logic [31:0] ctrl(logic go, logic [4:0] fn,
         logic [3:0] fm);
      ctrl = '0;
      ctrl[CTRL_GO_BIT] = go;
      ctrl[CTRL_FUNC_LSB +: CTRL_FUNC_W] = fn;
      ctrl[CTRL_FMT_LSB +: FMT_W] = fm;
   endfunction

   task automatic send_frame(input logic [7:0] v);
      read_char_lines <= v;
      repeat (2) @(posedge clk);
      read_char_strobe <= 1'b1;
      repeat (4) @(posedge clk);
      read_char_strobe <= 1'b0;
      repeat (4) @(posedge clk);
      read_char_lines <= ~v;
      repeat (2) @(posedge clk);
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic reset_regs;
      check("wait_rst", avs_waitrequest, 1'b1);
      check("state_rst", state_outs, 3'b000);
      bus_rd(ADDR_CTRL, rd);
      check("ctrl_rst", rd, 32'h0);
      bus_rd(4'h2, rd);
      check("unmapped", rd, 32'h0);
      bus_wr(ADDR_FRAMES, 32'h0001_1234);
      bus_rd(ADDR_FRAMES, rd);
      check("frames_rw", rd, 32'h1234);
   endtask

   task automatic func_codes;
      logic [4:0] c [5] = '{5'h00, 5'h08, 5'h10, 5'h18, 5'h1f};
      logic x;
      for (int i = 0; i < 5; i++) begin
         bus_wr(ADDR_CTRL, ctrl(1'b0, c[i], FMT_CORE_DUMP));
         repeat (2) @(posedge clk);
         x = (c[i] & FUNC_XFER_MASK) == FUNC_XFER_MATCH;
         check("occupied", transfer_occupied, x);
         check("enable", assembler_enable, x);
      end
   endtask

   task automatic fmt_codes;
      for (int f = 0; f < 16; f++) begin
         bus_wr(ADDR_CTRL, ctrl(1'b0, FUNC_XFER_MATCH, 4'(f)));
         repeat (2) @(posedge clk);
         check("fmt_err", format_error, f > 3);
      end
      bus_wr(ADDR_CTRL, ctrl(1'b0, FUNC_RESET, FMT_RESET));
   endtask

   task automatic run_words(input logic [3:0] fm, input logic [2:0] n,
         input int words, input logic [7:0] lag_v);
      logic [7:0] f [6];
      logic [35:0] exp;
      int base;
      lag <= lag_v;
      base = n_half;
      bus_wr(ADDR_FRAMES, 32'h10000 - 32'(n) * 32'(words));
      bus_wr(ADDR_CTRL, ctrl(1'b1, FUNC_XFER_MATCH, fm));
      for (int w = 0; w < words; w++) begin
         for (int k = 0; k < 6; k++) f[k] = 8'h3c ^ 8'(k * 71 + fm + w * 5);
         case (fm)
            FMT_CORE_DUMP: exp = {f[0], f[1], f[2], f[3], f[4][3:0]};
            FMT_SEVEN_TRACK: exp = {f[0][5:0], f[1][5:0], f[2][5:0],
               f[3][5:0], f[4][5:0], f[5][5:0]};
            FMT_ASCII: exp = {f[0][6:0], f[1][6:0], f[2][6:0], f[3][6:0],
               f[4]};
            default: exp = {f[0], f[1], f[2], f[3], 4'h0};
         endcase
         for (int k = 0; k < 600 && state_outs.first !== 1'b1; k++)
            @(posedge clk);
         check("init", state_outs, 3'b100);
         for (int k = 0; k < n; k++) send_frame(f[k]);
         for (int k = 0; k < 2000 && n_half != base + 2 * w + 2; k++)
            @(posedge clk);
         check("word", got_word, exp);
         check("parity", got_par, {~^exp[35:18], ~^exp[17:0]});
      end
      repeat (4) @(posedge clk);
      check("end_en", assembler_enable, 1'b0);
      bus_rd(ADDR_FRAMES, rd);
      check("count", rd, 32'h0);
   endtask

   // ------------------------------------------------------------
   // Main sequence and verdict
   // ------------------------------------------------------------
   task automatic complete_run;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         n_mismatch++;
         complete_run();
      end
   end

   initial begin
      {rst, avs_read, avs_write, read_char_strobe} = 4'hf;
      {avs_read, avs_write, read_char_strobe} = 3'h0;
      avs_address = '0;
      avs_writedata = '0;
      read_char_lines = '0;
      lag = '0;
      n_mismatch = 0;
      n_checks = 0;
      cyc = 0;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      reset_regs();
      func_codes();
      fmt_codes();
      run_words(FMT_CORE_DUMP, FRAMES_CORE_DUMP, 1, 8'h0);
      run_words(FMT_SEVEN_TRACK, FRAMES_SEVEN_TRACK, 2, 8'h28);
      run_words(FMT_ASCII, FRAMES_ASCII, 1, 8'h3);
      run_words(FMT_COMPAT, FRAMES_COMPAT, 1, 8'h5a);
      complete_run();
   end
endmodule // testbench
